// file: pin_driver.v
// Per-pin output stage: drives the latch value where a pin is general-purpose output
// Assumes function, direction and latch come from registers on the same clock
`timescale 1ns/1ps
`include "pin_output_defs.vh"
module pin_driver (
    input  wire        clock,
    input  wire        rst_n,
    input  wire [31:0] latch,
    input  wire [31:0] func_sel,
    input  wire [31:0] dir_sel,
    output reg  [31:0] pin_out,
    output reg  [31:0] pin_oe_n
);
    localparam [31:0] IMPL_MASK = `IMPLEMENTED_MASK;
    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1) begin : g_pin
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    pin_out[i]  <= 1'b0;
                    pin_oe_n[i] <= 1'b1;
                end else begin
                    pin_out[i]  <= latch[i];
                    pin_oe_n[i] <= ~(func_sel[i] & dir_sel[i] & IMPL_MASK[i]); // RQ13
                end
            end
        end
    endgenerate
endmodule

// file: pin_output_clear_alias.v
// Pin output latch with its write-only clear alias, behind an Avalon-MM slave
// Assumes a single clock domain and a master that holds requests until waitrequest is low
//
// Contract
// (RQ1) A 1 at bit 31 clears the receive frame-sync latch bit.
// (RQ2) A 1 at bit 30 clears the receive high-rate clock latch bit.
// (RQ3) A 1 at bit 29 clears the receive bit-clock latch bit.
// (RQ4) A 1 at bit 28 clears the transmit frame-sync latch bit.
// (RQ5) A 1 at bit 27 clears the transmit high-rate clock latch bit.
// (RQ6) A 1 at bit 26 clears the transmit bit-clock latch bit.
// (RQ7) A 1 at bit 25 clears the mute latch bit.
// (RQ8) A 1 at bit n, 15 to 0, clears serial data latch bit n.
// (RQ9) Zeros leave latch bits alone; each one touches only its own bit.
// (RQ10) Bits 24 to 16 read zero and writes to them do nothing.
// (RQ11) Software writes only zero to the reserved bits.
// (RQ12) The clear alias stores nothing; writes go straight to the latch.
// (RQ13) A cleared bit drives its pin low when general-purpose output.
// (RQ14) A clear write changes the latch in the cycle it is accepted.
`timescale 1ns/1ps
`include "pin_output_defs.vh"
module pin_output_clear_alias (
    input  wire        clock,
    input  wire        rst_n,
    input  wire [3:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    input  wire [3:0]  byteenable,
    output wire        waitrequest,
    output reg  [31:0] readdata,
    input  wire [31:0] pin_in,
    output wire [31:0] pin_out,
    output wire [31:0] pin_oe_n,
    output wire [31:0] pin_output_latch
);
    // ----------------------------------------------------------------
    // Registers and bus decode
    // ----------------------------------------------------------------
    localparam ST_IDLE = 2'b01;
    localparam ST_DONE = 2'b10;

    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [31:0] latch_reg;
    reg  [31:0] latch_next;
    reg  [31:0] func_reg;
    reg  [31:0] dir_reg;
    reg  [31:0] readdata_next;
    wire [31:0] pin_synced;
    wire [31:0] lane_mask;
    wire [5:0]  byte_addr;
    wire        access;
    wire        accept;

    assign byte_addr = {address, 2'b00};
    assign access    = read | write;
    assign accept    = access & (state_reg == ST_IDLE);
    assign waitrequest = access & (state_reg != ST_DONE);
    assign lane_mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                        {8{byteenable[1]}}, {8{byteenable[0]}}};
    assign pin_output_latch = latch_reg;

    // ----------------------------------------------------------------
    // Handshake: accept in idle, answer one cycle later
    // ----------------------------------------------------------------
    always @* begin
        case (state_reg)
            ST_IDLE: state_next = access ? ST_DONE : ST_IDLE;
            ST_DONE: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // Latch update
    // ----------------------------------------------------------------
    always @* begin
        latch_next = latch_reg;
        if (accept && write) begin
            case (byte_addr)
                `OFS_PIN_OUTPUT_LATCH:
                    latch_next = (latch_reg & ~lane_mask)
                               | (writedata & lane_mask & `IMPLEMENTED_MASK);
                `OFS_PIN_OUTPUT_CLEAR:
                    latch_next = latch_reg & ~(writedata & lane_mask
                               & `IMPLEMENTED_MASK); // RQ1 RQ2 RQ3 RQ4 RQ5 RQ6 RQ7 RQ8 RQ9 RQ10 RQ12 RQ14
                default:
                    latch_next = latch_reg;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    always @* begin
        readdata_next = 32'h00000000;
        if (accept && read) begin
            case (byte_addr)
                `OFS_PIN_FUNCTION_SELECT:  readdata_next = func_reg;
                `OFS_PIN_DIRECTION_SELECT: readdata_next = dir_reg;
                `OFS_PIN_INPUT_STATE:      readdata_next = pin_synced & `IMPLEMENTED_MASK;
                `OFS_PIN_OUTPUT_LATCH:     readdata_next = latch_reg;
                `OFS_PIN_OUTPUT_CLEAR:     readdata_next = 32'h00000000; // RQ12
                default:                   readdata_next = 32'h00000000;
            endcase
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            latch_reg <= `RST_PIN_OUTPUT_LATCH;
            func_reg  <= `RST_PIN_FUNCTION_SELECT;
            dir_reg   <= `RST_PIN_DIRECTION_SELECT;
            readdata  <= 32'h00000000;
        end else begin
            state_reg <= state_next;
            latch_reg <= latch_next; // RQ14
            if (accept && read) begin
                readdata <= readdata_next;
            end
            if (accept && write && byte_addr == `OFS_PIN_FUNCTION_SELECT) begin
                func_reg <= (func_reg & ~lane_mask)
                          | (writedata & lane_mask & `IMPLEMENTED_MASK);
            end
            if (accept && write && byte_addr == `OFS_PIN_DIRECTION_SELECT) begin
                dir_reg <= (dir_reg & ~lane_mask)
                         | (writedata & lane_mask & `IMPLEMENTED_MASK);
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin stages
    // ----------------------------------------------------------------
    pin_sync u_sync (
        .clock      (clock),
        .rst_n      (rst_n),
        .pin_async  (pin_in),
        .pin_synced (pin_synced)
    );

    pin_driver u_drv (
        .clock    (clock),
        .rst_n    (rst_n),
        .latch    (latch_reg),
        .func_sel (func_reg),
        .dir_sel  (dir_reg),
        .pin_out  (pin_out),
        .pin_oe_n (pin_oe_n)
    );
endmodule

// file: pin_output_clear_alias_bench.sv
// Self-checking bench for the pin output clear alias block
// Assumes the block answers every access over Avalon-MM
`timescale 1ns/1ps
module pin_output_clear_alias_bench;
    // ----------------------------------------------------------------
    // Signals and instance
    // ----------------------------------------------------------------
    logic        clock, rst_n, read, write;
    logic [3:0]  address, byteenable;
    logic [31:0] writedata, pin_in, q;
    wire         waitrequest;
    wire  [31:0] readdata, pin_out, pin_oe_n, pin_output_latch;
    int          miscompares, n_compared;
    logic [63:0] rows [0:9] = '{64'h80000000_7e00ffff, 64'h40000000_be00ffff,
        64'h20000000_de00ffff, 64'h10000000_ee00ffff, 64'h08000000_f600ffff,
        64'h04000000_fa00ffff, 64'h02000000_fc00ffff, 64'h0000a5a5_fe005a5a,
        64'h01ff0000_fe00ffff, 64'h00000000_fe00ffff};
    pin_output_clear_alias i_pin_output_clear_alias (.clock(clock), .rst_n(rst_n),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .waitrequest(waitrequest), .readdata(readdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_output_latch(pin_output_latch));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        @(posedge clock);
        write <= wr; read <= !wr; address <= a; writedata <= d; byteenable <= be;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        if (n >= 20) miscompares++;
    endtask
    // ----------------------------------------------------------------
    // Clock, watchdog and tests
    // ----------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        #100000;
        miscompares++;
        close_out;
    end
    initial begin
        rst_n = 1'b0; read = 1'b0; write = 1'b0; address = 4'h0;
        byteenable = 4'h0; writedata = 32'h0; pin_in = 32'h12345678;
        miscompares = 0; n_compared = 0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        check(pin_oe_n, 32'hffffffff);
        for (int i = 0; i < 10; i++) begin
            bus(1'b1, 4'h7, 32'hffffffff, 4'hf);
            bus(1'b1, 4'h8, rows[i][63:32], 4'hf);
            check(pin_output_latch, rows[i][31:0]);
        end
        $display("clear rows done");
        bus(1'b0, 4'h8, 32'h0, 4'hf);
        check(q, 32'h0);
        bus(1'b0, 4'h7, 32'h0, 4'hf);
        check(q, 32'hfe00ffff);
        bus(1'b0, 4'hf, 32'h0, 4'hf);
        check(q, 32'h0);
        bus(1'b0, 4'h2, 32'h0, 4'hf);
        check(q, 32'h12005678);
        $display("read tests done");
        bus(1'b1, 4'h0, 32'hffffffff, 4'hf);
        bus(1'b1, 4'h1, 32'hffffffff, 4'hf);
        bus(1'b1, 4'h8, 32'h80000001, 4'h1);
        check(pin_output_latch, 32'hfe00fffe);
        repeat (2) @(posedge clock);
        check(pin_out, 32'hfe00fffe);
        check(pin_oe_n, 32'h01ff0000);
        rst_n <= 1'b0;
        @(posedge clock);
        check(pin_output_latch, 32'h0);
        rst_n <= 1'b1;
        $display("pin and reset tests done");
        close_out;
    end
endmodule

// file: pin_output_clear_alias_monitor.sv
// Assertions on the ports of the pin output clear alias block
// Assumes one clock, reset rst_n, bound to the top module
`timescale 1ns/1ps
module pin_output_clear_alias_monitor (
    input wire        clock,
    input wire        rst_n,
    input wire [3:0]  address,
    input wire        read,
    input wire        write,
    input wire [31:0] writedata,
    input wire [3:0]  byteenable,
    input wire        waitrequest,
    input wire [31:0] readdata,
    input wire [31:0] pin_in,
    input wire [31:0] pin_out,
    input wire [31:0] pin_oe_n,
    input wire [31:0] pin_output_latch
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    wire        clr = write && waitrequest && address == 4'h8;
    wire [31:0] m   = writedata & {{8{byteenable[3]}}, {8{byteenable[2]}},
                                   {8{byteenable[1]}}, {8{byteenable[0]}}};
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_ctrl; clr |=> (pin_output_latch[31:25] & $past(m[31:25])) == 7'h00; endproperty
    a_ctrl: assert property (p_ctrl) else $error("control pin bit not cleared");
    property p_data; clr |=> (pin_output_latch[15:0] & $past(m[15:0])) == 16'h0000; endproperty
    a_data: assert property (p_data) else $error("data pin bit not cleared");
    property p_keep; clr |=> (pin_output_latch & ~$past(m)) == ($past(pin_output_latch) & ~$past(m)); endproperty
    a_keep: assert property (p_keep) else $error("unselected latch bit changed");
    property p_resv; pin_output_latch[24:16] == 9'h000 && readdata[24:16] == 9'h000; endproperty
    a_resv: assert property (p_resv) else $error("reserved bits not zero");
    property p_rdz; read && waitrequest && address == 4'h8 |=> readdata == 32'h0; endproperty
    a_rdz: assert property (p_rdz) else $error("clear alias read not zero");
    property p_pin; 1'b1 |=> pin_out == $past(pin_output_latch); endproperty
    a_pin: assert property (p_pin) else $error("pin level does not follow latch");
    property p_wait; (read || write) && waitrequest |=> !waitrequest; endproperty
    a_wait: assert property (p_wait) else $error("access not answered next cycle");
    property p_stable; !(write && waitrequest) |=> $stable(pin_output_latch); endproperty
    a_stable: assert property (p_stable) else $error("latch changed without a write");
    c_clr: cover property (clr);
    c_rdz: cover property (read && waitrequest && address == 4'h8);
    c_lat: cover property (write && waitrequest && address == 4'h7);
endmodule
bind pin_output_clear_alias pin_output_clear_alias_monitor i_pin_output_clear_alias_monitor (
    .clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .waitrequest(waitrequest),
    .readdata(readdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_output_latch(pin_output_latch));

// file: pin_output_defs.vh
// Constants for the pin output clear alias block
// Assumes a 32-bit Avalon-MM register bus with word addresses; the offsets below are in bytes
`ifndef PIN_OUTPUT_DEFS_VH
`define PIN_OUTPUT_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_PIN_OUTPUT_LATCH     6'h1c
`define OFS_PIN_OUTPUT_CLEAR     6'h20
`define OFS_PIN_FUNCTION_SELECT  6'h00
`define OFS_PIN_DIRECTION_SELECT 6'h04
`define OFS_PIN_INPUT_STATE      6'h08

// ----------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------
`define BIT_RX_FRAME_SYNC        31
`define BIT_RX_HIGH_RATE_CLOCK   30
`define BIT_RX_BIT_CLOCK         29
`define BIT_TX_FRAME_SYNC        28
`define BIT_TX_HIGH_RATE_CLOCK   27
`define BIT_TX_BIT_CLOCK         26
`define BIT_MUTE                 25
`define SERIAL_DATA_COUNT        16
`define IMPLEMENTED_MASK         32'hfe00ffff

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_PIN_OUTPUT_LATCH     32'h00000000
`define RST_PIN_FUNCTION_SELECT  32'h00000000
`define RST_PIN_DIRECTION_SELECT 32'h00000000

`endif

// file: pin_sync.v
// Two-stage synchroniser for the pin input levels
// Assumes the pins are asynchronous to clock
`timescale 1ns/1ps
module pin_sync (
    input  wire        clock,
    input  wire        rst_n,
    input  wire [31:0] pin_async,
    output reg  [31:0] pin_synced
);
    reg [31:0] stage_reg;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage_reg  <= 32'h00000000;
            pin_synced <= 32'h00000000;
        end else begin
            stage_reg  <= pin_async;
            pin_synced <= stage_reg;
        end
    end
endmodule
